// [hdl/gvtm_monitor.sv]
// Overview of operation
// RQ1 - One voltage and one temperature converter, each giving a 3-bit code.
// RQ2 - A flag rises when a sensor code leaves its programmed limits.
// RQ3 - Raised sensor flags can be sent to the linked deserializer.
// RQ4 - Temperature alarm bit set when the code leaves the temperature range.
// RQ5 - Only the first two pins can feed the voltage converter.
// RQ6 - Voltage code 000 below 0.85 V, 111 above 1.15 V, 50 mV bands.
// RQ7 - Temperature code 000 below -30 C, 111 above 100 C, fixed bands.
// RQ8 - Four pins, seen and set through registers 0x0D, 0x0E, 0x53.
// RQ9 - Register 0x53 returns the level of each pin, one bit each.
// RQ10 - Pin readback is valid when that pin's listen enable is set.
// RQ11 - Software sets listen and drive enables to read back a driven pin.
// RQ12 - Listen enable connects the pin pull-down, even while driving.
// RQ13 - Status 0x57 bits 2 and 3 give voltage below or above limits.
// RQ14 - Register 0x17 enables sensing and picks the pin; 0x3E picks pin 1.
// RQ15 - Alarms armed in 0x1D; forwarding enabled separately in 0x1E.
// RQ16 - Status always sent to deserializer; alarms only when enabled.
// RQ17 - Voltage levels and alarms at 0x58, 0x59; temperature at 0x5A.
// RQ18 - High alarm above upper, low below lower, checked every conversion.
`timescale 1ns/1ns
`default_nettype none
`include "gvtm_params.svh"

module gvtm_monitor #(
  parameter int unsigned CONV_CYCLES =
    `GVTM_CONV_NS * `GVTM_CLK_MHZ / `GVTM_NS_PER_US
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic [`GVTM_AW-1:0]       reg_addr_i,
  input  wire logic                      reg_wr_i,
  input  wire logic [`GVTM_DW-1:0]       reg_wdata_i,
  input  wire logic                      reg_rd_i,
  output logic [`GVTM_DW-1:0]            reg_rdata_o,
  input  wire logic [`GVTM_NPINS-1:0]    pin_in_i,
  output logic [`GVTM_NPINS-1:0]         pin_out_o,
  output logic [`GVTM_NPINS-1:0]         pin_oe_n_o,
  output logic [`GVTM_NPINS-1:0]         pin_pulldown_o,
  output logic [`GVTM_NPINS-1:0]         pin_level_valid_o,
  input  wire logic [`GVTM_NPINS-1:0]    remote_gpio_i,
  input  wire logic [`GVTM_MVW-1:0]      sense_mv_a_i,
  input  wire logic [`GVTM_MVW-1:0]      sense_mv_b_i,
  input  wire logic signed [`GVTM_TW-1:0] temp_c_i,
  output logic [2*`GVTM_DW-1:0]          remote_sensor_report_o,
  output logic                           report_strobe_o
);

  localparam logic [`GVTM_CNTW-1:0] CNT_RELOAD =
    `GVTM_CNTW'(CONV_CYCLES - 1);
  localparam int CONV_D = int'(CONV_CYCLES);
  localparam logic [`GVTM_NTHR*`GVTM_VW-1:0] VTHR = `GVTM_VTHR;
  localparam logic [`GVTM_NTHR*`GVTM_TW-1:0] TTHR = `GVTM_TTHR;
  localparam logic signed [`GVTM_VW-1:0] VT_FIRST = VTHR[`GVTM_VW-1:0];
  localparam logic signed [`GVTM_VW-1:0] VT_LAST =
    VTHR[`GVTM_NTHR*`GVTM_VW-1 -: `GVTM_VW];
  localparam logic signed [`GVTM_TW-1:0] TT_FIRST = TTHR[`GVTM_TW-1:0];
  localparam logic signed [`GVTM_TW-1:0] TT_LAST =
    TTHR[`GVTM_NTHR*`GVTM_TW-1 -: `GVTM_TW];
  localparam gvtm_pkg::gvtm_code_t CODE_MIN = '0;
  localparam gvtm_pkg::gvtm_code_t CODE_MAX = '1;
  localparam gvtm_pkg::gvtm_state_t RST = '{
    local_sel: `GVTM_RST_LOCAL,
    dir:       `GVTM_RST_DIR,
    scfg:      `GVTM_RST_SCFG,
    gain:      `GVTM_RST_GAIN,
    vlim:      `GVTM_RST_VLIM,
    tlim:      `GVTM_RST_TLIM,
    aen:       `GVTM_RST_AEN,
    fwd:       `GVTM_RST_FWD,
    pin_oe_n:  '1,
    default:   '0
  };

  gvtm_pkg::gvtm_state_t         q;
  gvtm_pkg::gvtm_state_t         n;
  logic signed [`GVTM_VW-1:0]    v_val;
  gvtm_pkg::gvtm_code_t          v_code;
  logic                          v_low;
  logic                          v_high;
  logic                          v_done;
  gvtm_pkg::gvtm_code_t          t_code;
  logic                          t_low;
  logic                          t_high;
  logic                          t_done;
  gvtm_pkg::gvtm_byte_t          stat;
  gvtm_pkg::gvtm_byte_t          fwd_alarm;
  logic [`GVTM_NPINS-1:0]        pin_listen_enable;
  logic [`GVTM_NPINS-1:0]        pin_drive_enable;
  logic [`GVTM_NPINS-1:0]        pin_level_register;

  assign pin_listen_enable  = q.dir[`GVTM_LO_NIB];
  assign pin_drive_enable   = q.dir[`GVTM_HI_NIB];
  // RQ10 listen-gated readback
  assign pin_level_register = pin_in_i & pin_listen_enable;

  // RQ5 first two pins only
  assign v_val = q.scfg[`GVTM_SCFG_PSEL] ? {1'b0, sense_mv_b_i}
                                         : {1'b0, sense_mv_a_i};

  // RQ6 voltage bands
  gvtm_quant #(
    .W   (`GVTM_VW),
    .THR (VTHR)
  ) u_volt (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .enable_i (q.scfg[`GVTM_SCFG_VEN]),
    .sample_i (q.tick),
    .value_i  (v_val),
    .lim_lo_i (q.vlim[`GVTM_LIM_LO]),
    .lim_hi_i (q.vlim[`GVTM_LIM_HI]),
    .code_o   (v_code),
    .low_o    (v_low),
    .high_o   (v_high),
    .done_o   (v_done)
  );

  // RQ7 temperature bands
  gvtm_quant #(
    .W   (`GVTM_TW),
    .THR (TTHR)
  ) u_temp (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .enable_i (q.scfg[`GVTM_SCFG_TEN]),
    .sample_i (q.tick),
    .value_i  (temp_c_i),
    .lim_lo_i (q.tlim[`GVTM_LIM_LO]),
    .lim_hi_i (q.tlim[`GVTM_LIM_HI]),
    .code_o   (t_code),
    .low_o    (t_low),
    .high_o   (t_high),
    .done_o   (t_done)
  );

  // Level byte: code plus armed alarms
  function automatic gvtm_pkg::gvtm_byte_t level_byte(
    input gvtm_pkg::gvtm_code_t code,
    input logic                 lo,
    input logic                 hi
  );
    gvtm_pkg::gvtm_byte_t b;
    b                = '0;
    b[`GVTM_LV_CODE] = code;
    b[`GVTM_LV_LO]   = lo;
    b[`GVTM_LV_HI]   = hi;
    return b;
  endfunction

  // Read decode
  function automatic gvtm_pkg::gvtm_byte_t rd_mux(
    input logic [`GVTM_AW-1:0]  addr,
    input gvtm_pkg::gvtm_state_t s,
    input logic [`GVTM_NPINS-1:0] pins,
    input gvtm_pkg::gvtm_byte_t st
  );
    gvtm_pkg::gvtm_byte_t r;
    r = '0;
    case (addr)
      `GVTM_OFS_LOCAL: r = s.local_sel;
      `GVTM_OFS_DIR:   r = s.dir;
      `GVTM_OFS_SCFG:  r = s.scfg;
      `GVTM_OFS_GAIN:  r = s.gain;
      `GVTM_OFS_VLIM:  r = s.vlim;
      `GVTM_OFS_TLIM:  r = s.tlim;
      `GVTM_OFS_AEN:   r = s.aen;
      `GVTM_OFS_FWD:   r = s.fwd;
      `GVTM_OFS_PINS:  r[`GVTM_LO_NIB] = pins;
      `GVTM_OFS_STAT:  r = st;
      `GVTM_OFS_LVA:   r = s.lva;
      `GVTM_OFS_LVB:   r = s.lvb;
      `GVTM_OFS_LTMP:  r = s.ltmp;
      default:         r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    // RQ2 live out-of-limit flags
    stat                = '0;
    stat[`GVTM_ST_TLO]  = t_low;
    stat[`GVTM_ST_THI]  = t_high;
    // RQ13 voltage below or above
    stat[`GVTM_ST_VLO]  = v_low;
    stat[`GVTM_ST_VHI]  = v_high;
    // RQ15 armed then forwarded
    fwd_alarm               = '0;
    fwd_alarm[`GVTM_AEN_VLO] = v_low & q.aen[`GVTM_AEN_VLO]
                               & q.fwd[`GVTM_FWD_V];
    fwd_alarm[`GVTM_AEN_VHI] = v_high & q.aen[`GVTM_AEN_VHI]
                               & q.fwd[`GVTM_FWD_V];
    fwd_alarm[`GVTM_AEN_TLO] = t_low & q.aen[`GVTM_AEN_TLO]
                               & q.fwd[`GVTM_FWD_T];
    fwd_alarm[`GVTM_AEN_THI] = t_high & q.aen[`GVTM_AEN_THI]
                               & q.fwd[`GVTM_FWD_T];

    n      = q;
    n.tick = 1'b0;
    n.rstb = 1'b0;

    // Conversion pacing
    if (q.cnt == '0) begin
      n.cnt  = CNT_RELOAD;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt - 1'b1;
    end

    // RQ8 register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `GVTM_OFS_LOCAL: n.local_sel = reg_wdata_i;
        `GVTM_OFS_DIR:   n.dir       = reg_wdata_i;
        // RQ14 enable and pin select
        `GVTM_OFS_SCFG:  n.scfg      = reg_wdata_i;
        `GVTM_OFS_GAIN:  n.gain      = reg_wdata_i;
        `GVTM_OFS_VLIM:  n.vlim      = reg_wdata_i;
        `GVTM_OFS_TLIM:  n.tlim      = reg_wdata_i;
        `GVTM_OFS_AEN:   n.aen       = reg_wdata_i;
        `GVTM_OFS_FWD:   n.fwd       = reg_wdata_i;
        default:         n.fwd       = q.fwd;
      endcase
    end

    // RQ9 pin level readback
    if (reg_rd_i) begin
      n.rdata = rd_mux(reg_addr_i, q, pin_level_register, stat);
    end

    // RQ17 voltage level registers
    if (v_done) begin
      if (q.scfg[`GVTM_SCFG_PSEL]) begin
        n.lvb = level_byte(v_code, v_low & q.aen[`GVTM_AEN_VLO],
                           v_high & q.aen[`GVTM_AEN_VHI]);
      end else begin
        n.lva = level_byte(v_code, v_low & q.aen[`GVTM_AEN_VLO],
                           v_high & q.aen[`GVTM_AEN_VHI]);
      end
    end

    // RQ4 temperature alarm
    if (t_done) begin
      n.ltmp = level_byte(t_code, t_low & q.aen[`GVTM_AEN_TLO],
                          t_high & q.aen[`GVTM_AEN_THI]);
    end

    // RQ3 report over control channel
    // RQ16 status always, alarms gated
    if (v_done || t_done) begin
      n.report = {fwd_alarm, stat};
      n.rstb   = 1'b1;
    end

    // Pin drivers, local or remote data
    n.pin_out  = (q.local_sel[`GVTM_HI_NIB] & remote_gpio_i)
               | (~q.local_sel[`GVTM_HI_NIB] & q.local_sel[`GVTM_LO_NIB]);
    n.pin_oe_n = ~pin_drive_enable;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o            = q.rdata;
  assign pin_out_o              = q.pin_out;
  assign pin_oe_n_o             = q.pin_oe_n;
  // RQ12 pull-down follows listen
  assign pin_pulldown_o         = pin_listen_enable;
  // RQ11 readback needs listen enable
  assign pin_level_valid_o      = pin_listen_enable;
  assign remote_sensor_report_o = q.report;
  assign report_strobe_o        = q.rstb;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  conv_period_a: assert property ( // RQ18
    q.tick |-> ##[CONV_D:CONV_D] q.tick)
    else $error("conversion interval wrong");

  volt_floor_a: assert property ( // RQ6
    v_done |-> ((v_code == CODE_MIN) == ($past(v_val) < VT_FIRST)))
    else $error("voltage low band wrong");

  volt_top_a: assert property ( // RQ6
    v_done |-> ((v_code == CODE_MAX) == ($past(v_val) >= VT_LAST)))
    else $error("voltage top band wrong");

  temp_bands_a: assert property ( // RQ7
    t_done |-> ((t_code == CODE_MIN) == ($past(temp_c_i) < TT_FIRST))
               && ((t_code == CODE_MAX) == ($past(temp_c_i) >= TT_LAST)))
    else $error("temperature band wrong");

  volt_limits_a: assert property ( // RQ2
    v_done |-> (v_low == (v_code < $past(q.vlim[`GVTM_LIM_LO])))
               && (v_high == (v_code > $past(q.vlim[`GVTM_LIM_HI]))))
    else $error("voltage limit compare wrong");

  stat_read_a: assert property ( // RQ13
    reg_rd_i && reg_addr_i == `GVTM_OFS_STAT
    |=> reg_rdata_o[`GVTM_ST_VLO] == $past(v_low)
        && reg_rdata_o[`GVTM_ST_VHI] == $past(v_high))
    else $error("status readback wrong");

  pin_read_a: assert property ( // RQ9
    reg_rd_i && reg_addr_i == `GVTM_OFS_PINS
    |=> reg_rdata_o == {4'h0, $past(pin_in_i) & $past(q.dir[`GVTM_LO_NIB])})
    else $error("pin level readback wrong");

  pulldown_a: assert property ( // RQ12
    reg_wr_i && reg_addr_i == `GVTM_OFS_DIR
    |=> pin_pulldown_o == $past(reg_wdata_i[`GVTM_LO_NIB]))
    else $error("pull-down not following listen enable");

  level_b_a: assert property ( // RQ14
    v_done && q.scfg[`GVTM_SCFG_PSEL]
    |=> q.lvb[`GVTM_LV_CODE] == $past(v_code) && $stable(q.lva))
    else $error("second pin level not stored");

  temp_alarm_a: assert property ( // RQ4
    t_done && t_high && q.aen[`GVTM_AEN_THI] |=> q.ltmp[`GVTM_LV_HI])
    else $error("temperature alarm missing");

  unarmed_a: assert property ( // RQ15
    t_done && !q.aen[`GVTM_AEN_THI] |=> !q.ltmp[`GVTM_LV_HI])
    else $error("unarmed alarm set");

  report_due_a: assert property ( // RQ3
    (v_done || t_done) |=> report_strobe_o
      && remote_sensor_report_o[`GVTM_DW-1:0] == $past(stat))
    else $error("report not sent");

  fwd_gate_a: assert property ( // RQ16
    report_strobe_o && !$past(q.fwd[`GVTM_FWD_V])
    |-> remote_sensor_report_o[`GVTM_DW+`GVTM_AEN_VHI] == 1'b0
        && remote_sensor_report_o[`GVTM_DW+`GVTM_AEN_VLO] == 1'b0)
    else $error("voltage alarm forwarded while disabled");

  level_reg_a: assert property ( // RQ17
    reg_rd_i && reg_addr_i == `GVTM_OFS_LTMP
    |=> reg_rdata_o == $past(q.ltmp))
    else $error("temperature level readback wrong");

  cov_volt_high: cover property (v_done && v_high);
  cov_alarm_sent: cover property (
    report_strobe_o && remote_sensor_report_o[2*`GVTM_DW-1:`GVTM_DW] != '0);
  cov_pin_read: cover property (
    reg_rd_i && reg_addr_i == `GVTM_OFS_PINS && pin_drive_enable != '0);
  cov_temp_low: cover property (t_done && t_low);

endmodule // gvtm_monitor

`default_nettype wire

// [hdl/gvtm_params.svh]
`ifndef GVTM_PARAMS_SVH
`define GVTM_PARAMS_SVH

// Bus and data widths
`define GVTM_AW        8
`define GVTM_DW        8
`define GVTM_CW        3
`define GVTM_NPINS     4
`define GVTM_NTHR      7
`define GVTM_VW        13
`define GVTM_MVW       12
`define GVTM_TW        8
`define GVTM_CNTW      16

// Register offsets
`define GVTM_OFS_LOCAL 8'h0d
`define GVTM_OFS_DIR   8'h0e
`define GVTM_OFS_SCFG  8'h17
`define GVTM_OFS_GAIN  8'h18
`define GVTM_OFS_VLIM  8'h1a
`define GVTM_OFS_TLIM  8'h1b
`define GVTM_OFS_AEN   8'h1d
`define GVTM_OFS_FWD   8'h1e
`define GVTM_OFS_PINS  8'h53
`define GVTM_OFS_STAT  8'h57
`define GVTM_OFS_LVA   8'h58
`define GVTM_OFS_LVB   8'h59
`define GVTM_OFS_LTMP  8'h5a

// Reset values
`define GVTM_RST_LOCAL 8'h00
`define GVTM_RST_DIR   8'h0f
`define GVTM_RST_SCFG  8'h00
`define GVTM_RST_GAIN  8'h80
`define GVTM_RST_VLIM  8'h62
`define GVTM_RST_TLIM  8'h61
`define GVTM_RST_AEN   8'h00
`define GVTM_RST_FWD   8'h00

// Field positions
`define GVTM_LO_NIB    3:0
`define GVTM_HI_NIB    7:4
`define GVTM_SCFG_TEN  1
`define GVTM_SCFG_VEN  2
`define GVTM_SCFG_PSEL 3
`define GVTM_LIM_LO    2:0
`define GVTM_LIM_HI    6:4
`define GVTM_AEN_VLO   0
`define GVTM_AEN_VHI   1
`define GVTM_AEN_TLO   2
`define GVTM_AEN_THI   3
`define GVTM_FWD_V     0
`define GVTM_FWD_T     1
`define GVTM_ST_TLO    0
`define GVTM_ST_THI    1
`define GVTM_ST_VLO    2
`define GVTM_ST_VHI    3
`define GVTM_LV_CODE   2:0
`define GVTM_LV_LO     4
`define GVTM_LV_HI     5

// Code boundaries, highest first (index 0 lowest): 850..1150 mV and -30..100 C
`define GVTM_VTHR {13'h047e, 13'h044c, 13'h041a, 13'h03e8, \
                   13'h03b6, 13'h0384, 13'h0352}
`define GVTM_TTHR {8'h64, 8'h4b, 8'h37, 8'h23, 8'h0f, 8'hf6, 8'he2}

// Conversion interval
`define GVTM_CONV_NS   1000
`define GVTM_CLK_MHZ   125
`define GVTM_NS_PER_US 1000

`endif

// [hdl/gvtm_pkg.sv]
`default_nettype none
`include "gvtm_params.svh"

package gvtm_pkg;

  typedef logic [`GVTM_CW-1:0] gvtm_code_t;
  typedef logic [`GVTM_DW-1:0] gvtm_byte_t;

  typedef struct packed {
    gvtm_code_t code;
    logic       low;
    logic       high;
    logic       done;
  } gvtm_conv_t;

  typedef struct packed {
    gvtm_byte_t                  local_sel;
    gvtm_byte_t                  dir;
    gvtm_byte_t                  scfg;
    gvtm_byte_t                  gain;
    gvtm_byte_t                  vlim;
    gvtm_byte_t                  tlim;
    gvtm_byte_t                  aen;
    gvtm_byte_t                  fwd;
    gvtm_byte_t                  rdata;
    gvtm_byte_t                  lva;
    gvtm_byte_t                  lvb;
    gvtm_byte_t                  ltmp;
    logic [`GVTM_CNTW-1:0]       cnt;
    logic                        tick;
    logic [`GVTM_NPINS-1:0]      pin_out;
    logic [`GVTM_NPINS-1:0]      pin_oe_n;
    logic [2*`GVTM_DW-1:0]       report;
    logic                        rstb;
  } gvtm_state_t;

endpackage

`default_nettype wire

// [hdl/gvtm_quant.sv]
`timescale 1ns/1ns
`default_nettype none
`include "gvtm_params.svh"

module gvtm_quant #(
  parameter int unsigned             W   = `GVTM_VW,
  parameter logic [`GVTM_NTHR*W-1:0] THR = '0
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 enable_i,
  input  wire logic                 sample_i,
  input  wire logic signed [W-1:0]  value_i,
  input  wire gvtm_pkg::gvtm_code_t lim_lo_i,
  input  wire gvtm_pkg::gvtm_code_t lim_hi_i,
  output gvtm_pkg::gvtm_code_t      code_o,
  output logic                      low_o,
  output logic                      high_o,
  output logic                      done_o
);

  logic [`GVTM_NTHR-1:0] above;
  gvtm_pkg::gvtm_conv_t  q;
  gvtm_pkg::gvtm_conv_t  n;

  // Thermometer of band boundaries
  for (genvar g = 0; g < `GVTM_NTHR; g++) begin : g_thr
    assign above[g] = value_i >= $signed(THR[g*W +: W]);
  end

  function automatic gvtm_pkg::gvtm_code_t ones(
    input logic [`GVTM_NTHR-1:0] v
  );
    gvtm_pkg::gvtm_code_t c;
    c = '0;
    for (int i = 0; i < `GVTM_NTHR; i++) begin
      c = c + gvtm_pkg::gvtm_code_t'(v[i]);
    end
    return c;
  endfunction

  always_comb begin
    n      = q;
    n.done = 1'b0;
    if (!enable_i) begin
      n.low  = 1'b0;
      n.high = 1'b0;
    end else if (sample_i) begin
      // RQ1 three-bit code
      n.code = ones(above);
      // RQ18 limit compare
      n.low  = n.code < lim_lo_i;
      n.high = n.code > lim_hi_i;
      n.done = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign code_o = q.code;
  assign low_o  = q.low;
  assign high_o = q.high;
  assign done_o = q.done;

endmodule // gvtm_quant

`default_nettype wire

// [verification/gvtm_far_end.sv]
`timescale 1ns/1ns
`default_nettype none

module gvtm_far_end (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] report_i,
  input  wire logic        strobe_i,
  input  wire logic [3:0]  gpio_i,
  output logic      [3:0]  gpio_o,
  output logic      [15:0] last_o,
  output logic      [7:0]  count_o
);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gpio_o  <= 4'h0;
      last_o  <= 16'h0000;
      count_o <= 8'h00;
    end else begin
      // Back channel pin data
      gpio_o <= gpio_i;
      if (strobe_i) begin
        last_o  <= report_i;
        count_o <= count_o + 8'h01;
      end
    end
  end
endmodule // gvtm_far_end

`default_nettype wire

// [verification/gvtm_monitor_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module gvtm_monitor_bench;
  localparam int unsigned CONV = 8;
  localparam logic [15:0] RST [8] = '{16'h0d00, 16'h0e0f, 16'h1700,
    16'h1880, 16'h1a62, 16'h1d00, 16'h1e00, 16'h4000};
  localparam logic [15:0] RW [5] = '{16'h183c, 16'h1a53, 16'h1b52,
    16'h1a62, 16'h1b61};
  localparam int          TV [8] = '{-31, -30, -10, 15, 35, 55, 75, 100};
  logic              clk_i;
  logic              reset_i;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, n, st;
  logic              reg_wr, reg_rd, strobe;
  logic [3:0]        pin_in, pin_out, pin_oe_n, pin_pd, pin_valid;
  logic [3:0]        ext, gpio_set, gpio_far;
  logic [11:0]       mv_a, mv_b;
  logic signed [7:0] temp;
  logic [15:0]       report, far_last;
  logic [7:0]        far_count;
  int                err_count, compares, cycles;

  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);

  gvtm_monitor #(.CONV_CYCLES(CONV)) DUT (
    .clk_i                  (clk_i),
    .reset_i                (reset_i),
    .reg_addr_i             (reg_addr),
    .reg_wr_i               (reg_wr),
    .reg_wdata_i            (reg_wdata),
    .reg_rd_i               (reg_rd),
    .reg_rdata_o            (reg_rdata),
    .pin_in_i               (pin_in),
    .pin_out_o              (pin_out),
    .pin_oe_n_o             (pin_oe_n),
    .pin_pulldown_o         (pin_pd),
    .pin_level_valid_o      (pin_valid),
    .remote_gpio_i          (gpio_far),
    .sense_mv_a_i           (mv_a),
    .sense_mv_b_i           (mv_b),
    .temp_c_i               (temp),
    .remote_sensor_report_o (report),
    .report_strobe_o        (strobe)
  );

  gvtm_far_end far (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .report_i (report),
    .strobe_i (strobe),
    .gpio_i   (gpio_set),
    .gpio_o   (gpio_far),
    .last_o   (far_last),
    .count_o  (far_count)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    check($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
    cyc(1);
  endtask

  task automatic reports(input int k);
    int w;
    for (int i = 0; i < k; i++) begin
      w = 0;
      while (strobe !== 1'b1 && w < 4 * CONV) begin
        cyc(1);
        w++;
      end
      check("report strobe", {15'h0000, strobe}, 16'h0001);
      cyc(1);
    end
  endtask

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {ext, gpio_set, mv_a, mv_b, temp} = '0;
    {err_count, compares, cycles} = '0;
    reset_i = 1'b1;
    cyc(16);
    reset_i = 1'b0;
    cyc(2);
    foreach (RST[i]) rdc(RST[i][15:8], RST[i][7:0]);
    check("pull-down", 16'(pin_pd), 16'h000f);
    check("drive off", 16'(pin_oe_n), 16'h000f);
    $display("test reset done");
    foreach (RW[i]) begin
      wr(RW[i][15:8], RW[i][7:0]);
      rdc(RW[i][15:8], RW[i][7:0]);
    end
    wr(8'h53, 8'hff);
    rdc(8'h53, 8'h00);
    $display("test access done");
    ext = 4'hb;
    wr(8'h0e, 8'h05);
    rdc(8'h53, 8'h01);
    check("valid", 16'(pin_valid), 16'h0005);
    check("pull-down", 16'(pin_pd), 16'h0005);
    wr(8'h0e, 8'hf0);
    wr(8'h0d, 8'h0a);
    check("drive on", 16'(pin_oe_n), 16'h0000);
    check("pin out", 16'(pin_out), 16'h000a);
    wr(8'h0e, 8'hff);
    rdc(8'h53, 8'h0a);
    check("pull-down", 16'(pin_pd), 16'h000f);
    gpio_set = 4'h6;
    wr(8'h0d, 8'hf0);
    cyc(3);
    check("remote out", 16'(pin_out), 16'h0006);
    $display("test pins done");
    for (int s = 0; s < 2; s++) begin
      wr(8'h17, s ? 8'h02 : 8'h04);
      for (int c = 0; c < 8; c++) begin
        mv_a = (c == 0) ? 12'd849 : 12'(800 + 50 * c);
        temp = 8'(TV[c]);
        st = s ? {6'h00, c > 6, c < 1} : {4'h0, c > 6, c < 2, 2'b00};
        reports(2);
        rdc(s ? 8'h5a : 8'h58, 8'(c));
        rdc(8'h57, st);
        check("status sent", far_last, {8'h00, st});
      end
    end
    $display("test codes done");
    mv_a = 12'd800;
    mv_b = 12'd1200;
    temp = 8'sd20;
    wr(8'h17, 8'h3e);
    wr(8'h1d, 8'h3f);
    wr(8'h1e, 8'h00);
    reports(2);
    rdc(8'h59, 8'h27);
    rdc(8'h57, 8'h08);
    check("unforwarded", far_last, 16'h0008);
    wr(8'h1e, 8'h7f);
    reports(2);
    check("volt alarm", far_last, 16'h0208);
    temp = 8'sd110;
    reports(2);
    rdc(8'h5a, 8'h27);
    check("both alarms", far_last, 16'h0a0a);
    wr(8'h1e, 8'h01);
    reports(2);
    check("volt only", far_last, 16'h020a);
    wr(8'h1d, 8'h00);
    wr(8'h1e, 8'h7f);
    temp = 8'sd20;
    reports(2);
    check("disarmed", far_last, 16'h0008);
    rdc(8'h59, 8'h07);
    $display("test alarms done");
    wr(8'h17, 8'h00);
    cyc(2);
    n = far_count;
    cyc(4 * CONV);
    check("no report", 16'(far_count), 16'(n));
    $display("test disable done");
    give_verdict();
  end
endmodule // gvtm_monitor_bench

`default_nettype wire
